// file: shared/tteca_pkg.sv
// tteca_pkg: shared constants and types for the triple timer/event counter
// assumes a single 20 MHz system clock; machine cycle derived by a divider
package tteca_pkg;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int TTEC_CNT_W = 16;                  // full count width
    localparam int TTEC_BYTE_W = 8;                  // one count byte
    localparam int TTEC_OSC_PER_MC = 12;             // oscillator periods per machine cycle
    localparam int TTEC_MC_DIV = TTEC_OSC_PER_MC;    // clock edges per machine cycle
    localparam int TTEC_EDGE_MC = 2;                 // machine cycles to recognise an edge
    localparam logic [3:0] TTEC_DIV_LAST = 4'(TTEC_MC_DIV - 1);
    localparam logic [7:0] TTEC_BYTE_ONES = 8'hff;   // byte all ones
    localparam logic [15:0] TTEC_CNT_ONES = 16'hffff;
    localparam logic [15:0] TTEC_CNT_ZERO = 16'h0000;
    localparam logic [7:0] TTEC_BYTE_ONE = 8'h01;    // increment step
    // ------------------------------------------------------------
    // unit operating mode
    // ------------------------------------------------------------
    typedef enum logic {TTEC_MODE_TIMER, TTEC_MODE_COUNTER} tteca_mode_t;
endpackage

// file: design/tteca_unit.sv
// tteca_unit: one 16-bit timer/event counter unit
// assumes tick_in is a one-clock pulse per machine cycle and event_in is already synchronised
`timescale 1ns/1ps
module tteca_unit
    import tteca_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tick_in,                 // machine cycle strobe
    input wire logic run_in,                  // count enable
    input wire logic mode_in,                 // 0 timer, 1 counter
    input wire logic event_in,                // synchronised event pin
    output logic edge_out,                    // falling edge seen this tick
    output logic [7:0] count_low_byte_out,
    output logic [7:0] count_high_byte_out,
    output logic ovf_out                      // one-clock rollover pulse
);
    // ------------------------------------------------------------
    // sampling
    // ------------------------------------------------------------
    logic sample_q;                           // level at last machine cycle
    logic step;                               // advance this tick
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic ovf_q;

    // one sample per machine cycle only [RL5]
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_q <= 1'b0;
        end else if (tick_in) begin
            sample_q <= event_in;
        end
    end

    // high then low across consecutive samples [RL4] [RL5]
    assign edge_out = tick_in && sample_q && !event_in;
    // timer steps every machine cycle, counter on edge [RL2] [RL3]
    assign step = run_in && (mode_in == TTEC_MODE_TIMER ? tick_in : edge_out);

    // ------------------------------------------------------------
    // count bytes
    // ------------------------------------------------------------
    // low byte carries into high byte [RL1] [RL14]; result visible next cycle [RL6]
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_q <= '0;
            high_q <= '0;
        end else if (step) begin
            low_q <= low_q + TTEC_BYTE_ONE;
            if (low_q == TTEC_BYTE_ONES) begin
                high_q <= high_q + TTEC_BYTE_ONE;
            end
        end
    end

    // rollover pulse feeds the overflow flag [RL13]
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= step && ({high_q, low_q} == TTEC_CNT_ONES);
        end
    end

    assign count_low_byte_out = low_q;
    assign count_high_byte_out = high_q;
    assign ovf_out = ovf_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_carry_into_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL14]
        (step && low_q == TTEC_BYTE_ONES) |=> (high_q == $past(high_q) + TTEC_BYTE_ONE))
        else $error("low byte did not carry");
    a_sample_per_tick: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
        !tick_in |=> $stable(sample_q))
        else $error("input sampled off the machine cycle");
    a_timer_steps: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
        (tick_in && run_in && mode_in == TTEC_MODE_TIMER) |=> ({high_q, low_q} == $past({high_q, low_q}) + 16'h0001))
        else $error("timer missed a machine cycle");
    a_counter_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
        (mode_in == TTEC_MODE_COUNTER && !edge_out) |=> $stable({high_q, low_q}))
        else $error("counter moved without edge");
endmodule

// file: design/tteca_top.sv
// tteca_top: three timer/event counter units with an extended third unit
// assumes 20 MHz clk_in, asynchronous event pins, control straps held static by the core
`timescale 1ns/1ps
// Contract
// RL1: three units, each sixteen-bit low/high count
// RL2: each unit timer or event counter
// RL3: timer advances once per machine cycle
// RL4: counter advances on input falling edge
// RL5: sample input once per machine cycle
// RL6: new count visible next machine cycle
// RL7: edge needs two machine cycles
// RL8: source holds each level one cycle
// RL9: units raise periodic interrupt requests
// RL10: third unit sixteen-bit with output generator
// RL11: third unit captures count on event
// RL12: third unit reloads, counts up or down
// RL13: rollover sets overflow flag, drives interrupt
// RL14: low byte carries into high byte
module tteca_top
    import tteca_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] run_in,                  // per-unit count enable
    input wire logic [2:0] mode_in,                 // per-unit: 0 timer, 1 event counter
    input wire logic event_input_a_in,              // event pin of unit a
    input wire logic event_input_b_in,              // event pin of unit b
    input wire logic event_input_c_in,              // event pin of the extended unit
    input wire logic capture_pin_in,                // capture/reload trigger pin
    input wire logic capture_mode_in,               // 1 capture, 0 reload on trigger
    input wire logic trigger_enable_in,             // trigger pin enable
    input wire logic count_down_in,                 // extended unit direction
    input wire logic [15:0] reload_value_in,        // extended unit reload value
    input wire logic [2:0] ovf_clear_in,            // per-unit overflow flag clear
    output logic [7:0] count_low_byte_a_out,
    output logic [7:0] count_high_byte_a_out,
    output logic [7:0] count_low_byte_b_out,
    output logic [7:0] count_high_byte_b_out,
    output logic [15:0] count_c_out,
    output logic [15:0] capture_c_out,
    output logic [2:0] ovf_flag_out,                // sticky overflow flags
    output logic [2:0] irq_out,                     // interrupt requests
    output logic timer_output_out                   // toggles on third unit overflow
);
    // ------------------------------------------------------------
    // reset release and machine cycle divider
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;                                  // synchronised reset used everywhere
    logic [3:0] div_q;
    logic tick;

    // assertion async, release through two flops
    // a bare release could land near an edge and free some flops a cycle early,
    // so the whole block waits for this one synchronised copy
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // twelve oscillator periods form one machine cycle
    // the last divider count doubles as the machine cycle strobe,
    // so every sampler and counter below steps on the same clock
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= '0;
        end else if (div_q == TTEC_DIV_LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    // one clock wide; nothing below may treat it as a level
    assign tick = (div_q == TTEC_DIV_LAST);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // only the second stage is read by logic
    // bit order: 0 unit a, 1 unit b, 2 extended unit, 3 trigger pin
    // reset low is harmless: pins idle high, so release looks like a rise, never a fall
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {capture_pin_in, event_input_c_in, event_input_b_in, event_input_a_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ------------------------------------------------------------
    // units a and b
    // ------------------------------------------------------------
    logic [1:0] ovf_ab;
    logic [1:0] edge_ab;
    logic [7:0] low_ab [2];
    logic [7:0] high_ab [2];
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_unit
            // independent simple units [RL1] [RL2]
            // both share the divider, so their machine cycles line up
            tteca_unit u_unit (
                .clk_in(clk_in),
                .rst_n_in(rst_n_q),
                .tick_in(tick),
                .run_in(run_in[gi]),
                .mode_in(mode_in[gi]),
                .event_in(pin_sync_q[gi]),
                .edge_out(edge_ab[gi]),
                .count_low_byte_out(low_ab[gi]),
                .count_high_byte_out(high_ab[gi]),
                .ovf_out(ovf_ab[gi])
            );
        end
    endgenerate
    assign count_low_byte_a_out = low_ab[0];
    assign count_high_byte_a_out = high_ab[0];
    assign count_low_byte_b_out = low_ab[1];
    assign count_high_byte_b_out = high_ab[1];

    // ------------------------------------------------------------
    // extended unit c: always full sixteen bits
    // ------------------------------------------------------------
    logic samp_c_q;                                 // event pin, last machine cycle
    logic samp_t_q;                                 // trigger pin, last machine cycle
    logic edge_c;
    logic trig;
    logic step_c;
    logic [15:0] cnt_c_q;
    logic [15:0] cap_c_q;
    logic ovf_c;
    logic tout_q;

    // one sample per machine cycle for both pins [RL5]
    // a level shorter than one machine cycle may slip between two ticks and be lost
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            samp_c_q <= 1'b0;
            samp_t_q <= 1'b0;
        end else if (tick) begin
            samp_c_q <= pin_sync_q[2];
            samp_t_q <= pin_sync_q[3];
        end
    end

    // falling edge across two samples [RL4] [RL7]
    assign edge_c = tick && samp_c_q && !pin_sync_q[2];
    assign trig = tick && trigger_enable_in && samp_t_q && !pin_sync_q[3];
    assign step_c = run_in[2] && (mode_in[2] == TTEC_MODE_TIMER ? tick : edge_c);

    // rollover depends on direction
    // up rolls at all ones, down at zero; a stopped unit never rolls
    assign ovf_c = step_c && (count_down_in ? (cnt_c_q == TTEC_CNT_ZERO) : (cnt_c_q == TTEC_CNT_ONES));

    // count with reload on up rollover or trigger [RL10] [RL12]
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_c_q <= '0;
        end else if (trig && !capture_mode_in) begin
            cnt_c_q <= reload_value_in;             // external reload wins over a step
        end else if (ovf_c) begin
            // down counting underflows to all ones, only up counting reloads [RL12]
            cnt_c_q <= count_down_in ? TTEC_CNT_ONES : reload_value_in;
        end else if (step_c) begin
            cnt_c_q <= count_down_in ? cnt_c_q - 16'h0001 : cnt_c_q + 16'h0001;
        end
    end

    // capture running count on trigger [RL11]
    // the count is read before any update, so capture sees the running value
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cap_c_q <= '0;
        end else if (trig && capture_mode_in) begin
            cap_c_q <= cnt_c_q;
        end
    end

    // output generator toggles per overflow [RL10]
    // toggling halves the rollover rate, so the pin carries a square wave
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tout_q <= 1'b0;
        end else if (ovf_c) begin
            tout_q <= ~tout_q;
        end
    end

    assign count_c_out = cnt_c_q;
    assign capture_c_out = cap_c_q;
    assign timer_output_out = tout_q;

    // ------------------------------------------------------------
    // overflow flags and interrupts
    // ------------------------------------------------------------
    logic [2:0] ovf_ev;
    logic [2:0] flag_q;
    assign ovf_ev = {ovf_c, ovf_ab};

    // set wins over clear so no rollover is lost [RL13]
    // clear is a level: held high it keeps the flag low until a new rollover
    // units a and b register their rollover first, so they flag a clock later
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flag_q <= '0;
        end else begin
            flag_q <= ovf_ev | (flag_q & ~ovf_clear_in);
        end
    end
    assign ovf_flag_out = flag_q;
    // periodic requests follow the flags [RL9]
    assign irq_out = flag_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_tick_period: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL3]
        tick |=> !tick [*8] ##0 1'b1)
        else $error("machine cycle too short");
    a_flag_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL13]
        ovf_ev[2] |=> flag_q[2])
        else $error("overflow lost");
    a_irq_from_flag: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL9]
        irq_out == flag_q)
        else $error("irq not following flag");
    a_capture_value: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL11]
        (trig && capture_mode_in) |=> (cap_c_q == $past(cnt_c_q)))
        else $error("capture mismatch");
    a_reload_value: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL12]
        (ovf_c && !count_down_in && !trig) |=> (cnt_c_q == $past(reload_value_in)))
        else $error("reload mismatch");
    a_down_step: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL12]
        (step_c && count_down_in && !ovf_c && !trig) |=> (cnt_c_q == $past(cnt_c_q) - 16'h0001))
        else $error("down count wrong");
    a_tout_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL10]
        ovf_c |=> (tout_q != $past(tout_q)))
        else $error("output did not toggle");
    // a counted edge needs a fresh high sample, so the next one is two ticks away
    a_event_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL7]
        edge_c |=> (!edge_c) [*8] ##4 !edge_c)
        else $error("edges too close");

    // ------------------------------------------------------------
    // checks: extended unit count path
    // ------------------------------------------------------------
    // no step and no trigger: the count must not drift
    a_c_hold_idle: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL4]
        (!step_c && !trig) |=> $stable(cnt_c_q))
        else $error("extended count moved while idle");
    // a counted edge shows up at the very next clock
    a_c_visible_next: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL6]
        (edge_c && run_in[2] && mode_in[2] == TTEC_MODE_COUNTER && !count_down_in && !ovf_c && !trig)
        |=> (cnt_c_q == $past(cnt_c_q) + 16'h0001))
        else $error("counted edge not visible");
    // plain up step away from the rollover point
    a_c_up_step: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL12]
        (step_c && !count_down_in && !ovf_c && !trig) |=> (cnt_c_q == $past(cnt_c_q) + 16'h0001))
        else $error("up count wrong");
    // down rollover lands on all ones, not on the reload value
    a_c_down_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL12]
        (ovf_c && count_down_in && !trig) |=> (cnt_c_q == TTEC_CNT_ONES))
        else $error("down rollover wrong");
    // a reload trigger overrides any step in the same cycle
    a_reload_trigger: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL12]
        (trig && !capture_mode_in) |=> (cnt_c_q == $past(reload_value_in)))
        else $error("trigger reload wrong");

    // ------------------------------------------------------------
    // checks: capture register and output generator
    // ------------------------------------------------------------
    // the holding register keeps its value between captures
    a_capture_holds: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL11]
        !(trig && capture_mode_in) |=> $stable(cap_c_q))
        else $error("capture changed without trigger");
    // the output level only moves on a rollover
    a_tout_steady: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL10]
        !ovf_c |=> $stable(tout_q))
        else $error("output moved without rollover");

    // ------------------------------------------------------------
    // checks: overflow flags of all units
    // ------------------------------------------------------------
    // any rollover, whatever unit, leaves its flag set
    a_flag_all_set: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL13]
        (ovf_ev != 3'h0) |=> ((flag_q & $past(ovf_ev)) == $past(ovf_ev)))
        else $error("rollover flag not set");
    // a clear with no rollover in the same cycle drops the flag
    a_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_q) // [RL13]
        ((ovf_clear_in & ~ovf_ev) != 3'h0) |=> ((flag_q & $past(ovf_clear_in) & ~$past(ovf_ev)) == 3'h0))
        else $error("flag survived a clear");
endmodule

// file: testbench/tb_tteca_top.sv
// tb_tteca_top: self-checking bench for the triple timer/event counter
// assumes a 12-clock machine cycle and two-flop pin synchronisers in the design
`timescale 1ns/1ps
module tb_tteca_top;
    import tteca_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_in, reset_n_in;
    logic [2:0] run_in, mode_in, ovf_clear_in;       // per-unit controls
    logic event_input_a_in, event_input_b_in, event_input_c_in;
    logic capture_pin_in, capture_mode_in, trigger_enable_in, count_down_in;
    logic [15:0] reload_value_in;
    logic [7:0] lo_a, hi_a, lo_b, hi_b;              // byte counts of units a and b
    logic [15:0] cnt_c, cap_c;
    logic [2:0] flag, irq;
    logic tout;
    int bad_count, n_tests;
    tteca_top i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .run_in(run_in), .mode_in(mode_in),
        .event_input_a_in(event_input_a_in), .event_input_b_in(event_input_b_in),
        .event_input_c_in(event_input_c_in), .capture_pin_in(capture_pin_in),
        .capture_mode_in(capture_mode_in), .trigger_enable_in(trigger_enable_in),
        .count_down_in(count_down_in), .reload_value_in(reload_value_in), .ovf_clear_in(ovf_clear_in),
        .count_low_byte_a_out(lo_a), .count_high_byte_a_out(hi_a), .count_low_byte_b_out(lo_b),
        .count_high_byte_b_out(hi_b), .count_c_out(cnt_c), .capture_c_out(cap_c),
        .ovf_flag_out(flag), .irq_out(irq), .timer_output_out(tout));
    // ------------------------------------------------------------
    // clock, watchdog and shared helpers
    // ------------------------------------------------------------
    // 20 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // whole run needs about 4600 cycles; cut off well beyond that
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        results();
    end
    // inputs change and outputs are read at the falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // full count of one unit, bytes joined for units a and b
    function automatic logic [15:0] get_cnt(input int u);
        return (u == 0) ? {hi_a, lo_a} : (u == 1) ? {hi_b, lo_b} : cnt_c;
    endfunction
    task automatic set_ev(input int u, input logic v);
        if (u == 0) event_input_a_in = v;
        else if (u == 1) event_input_b_in = v;
        else event_input_c_in = v;
    endtask
    // bounded wait for the next count step; a stuck count is a mismatch
    task automatic wait_step(input int u, output logic [15:0] v);
        logic [15:0] old;
        int i;
        old = get_cnt(u);
        for (i = 0; i < 40 && get_cnt(u) === old; i++) cyc(1);
        if (i == 40) chk_val(old, old + 16'h0001);
        v = get_cnt(u);
    endtask
    // trigger pin falling edge, both levels held two machine cycles
    task automatic pulse_trig();
        capture_pin_in = 1'b0;
        cyc(24);
        capture_pin_in = 1'b1;
        cyc(24);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset clears every output, also when applied in mid-run
    task automatic t_reset();
        reset_n_in = 1'b0;
        cyc(4);
        chk_val({hi_a, lo_a}, 16'h0000);
        chk_val({hi_b, lo_b}, 16'h0000);
        chk_val(cnt_c, 16'h0000);
        chk_val(cap_c, 16'h0000);
        chk_val({13'h0, flag}, 16'h0000);
        chk_val({13'h0, irq}, 16'h0000);
        chk_bit(tout, 1'b0);
        reset_n_in = 1'b1;
        run_in = 3'h0;
        cyc(4);
    endtask
    // extended unit counting down from zero wraps to all ones and flags it
    task automatic t_c_down();
        logic [15:0] v;
        count_down_in = 1'b1;
        run_in[2] = 1'b1;
        wait_step(2, v);
        chk_val(v, 16'hffff);
        cyc(2);
        chk_bit(flag[2], 1'b1);
        chk_bit(irq[2], 1'b1);
        chk_bit(tout, 1'b1);
        wait_step(2, v);
        run_in[2] = 1'b0;
        chk_val(v, 16'hfffe);
        ovf_clear_in[2] = 1'b1;
        cyc(2);
        ovf_clear_in[2] = 1'b0;
        cyc(1);
        chk_bit(irq[2], 1'b0);
    endtask
    // reload by trigger, then count up through the rollover back to the reload
    task automatic t_reload_up();
        logic [15:0] v;
        count_down_in = 1'b0;
        capture_mode_in = 1'b0;
        reload_value_in = 16'hfffd;
        pulse_trig();
        chk_val(cnt_c, 16'hfffd);
        run_in[2] = 1'b1;
        wait_step(2, v);
        chk_val(v, 16'hfffe);
        wait_step(2, v);
        chk_val(v, 16'hffff);
        chk_bit(flag[2], 1'b0);
        wait_step(2, v);
        run_in[2] = 1'b0;
        chk_val(v, 16'hfffd);
        cyc(2);
        chk_bit(irq[2], 1'b1);
        chk_bit(tout, 1'b0);
    endtask
    // disabled trigger is ignored; enabled capture latches without reloading
    task automatic t_capture();
        capture_mode_in = 1'b1;
        reload_value_in = 16'h1234;
        trigger_enable_in = 1'b0;
        pulse_trig();
        chk_val(cap_c, 16'h0000);
        trigger_enable_in = 1'b1;
        pulse_trig();
        chk_val(cap_c, 16'hfffd);
        chk_val(cnt_c, 16'hfffd);
    endtask
    // event counting: slow edges checked one by one, then a burst at top rate
    task automatic t_counter(input int u);
        logic [15:0] base;
        set_ev(u, 1'b1);
        cyc(48);
        base = get_cnt(u);
        chk_val(base, 16'h0000);
        for (int k = 1; k <= 4; k++) begin
            set_ev(u, 1'b0);
            cyc(24);
            set_ev(u, 1'b1);
            cyc(12);
            chk_val(get_cnt(u), base + 16'(k));
            cyc(12);
        end
        // one machine cycle per level: the fastest legal input
        for (int k = 0; k < 8; k++) begin
            set_ev(u, 1'b0);
            cyc(12);
            set_ev(u, 1'b1);
            cyc(12);
        end
        cyc(30);
        chk_val(get_cnt(u), base + 16'h000c);
    endtask
    // timer steps once per machine cycle and stops when disabled
    task automatic t_timer_a();
        logic [15:0] v;
        mode_in[0] = 1'b0;
        run_in[0] = 1'b1;
        wait_step(0, v);
        cyc(240);
        chk_val(get_cnt(0), v + 16'h0014);
        run_in[0] = 1'b0;
        v = get_cnt(0);
        cyc(48);
        chk_val(get_cnt(0), v);
    endtask
    // low byte wrap carries into the high byte
    task automatic t_carry();
        logic [15:0] v;
        logic [7:0] h;
        int i;
        run_in[0] = 1'b1;
        for (i = 0; i < 4000 && lo_a !== 8'hff; i++) cyc(1);
        h = hi_a;
        wait_step(0, v);
        run_in[0] = 1'b0;
        chk_val(v, {h + 8'h01, 8'h00});
    endtask
    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        reset_n_in = 1'b0;
        {run_in, mode_in, ovf_clear_in} = 9'h000;
        {event_input_a_in, event_input_b_in, event_input_c_in, capture_pin_in} = 4'hf;
        {capture_mode_in, trigger_enable_in, count_down_in} = 3'h2;
        reload_value_in = 16'h0000;
        bad_count = 0;
        n_tests = 0;
        t_reset();
        t_c_down();
        t_reload_up();
        t_capture();
        t_reset();
        mode_in = 3'h7;
        run_in = 3'h7;
        for (int u = 0; u < 3; u++) t_counter(u);
        t_timer_a();
        t_carry();
        results();
    end
endmodule
